// ### rtl/cic_regs.sv
// charger input configuration registers behind an i2c slave
`timescale 1ns/1ps
module cic_regs
    import cic_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // i2c pins, sda is open drain
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // input source straps
    input wire logic otg_pin_i,
    input wire logic source_is_dcp_i,
    input wire logic [12:0] external_current_limit_pin_ma_i,
    // decoded settings
    output logic input_high_z_enable_o,
    output logic [12:0] input_voltage_limit_mv_o,
    output logic [12:0] input_current_limit_ma_o,
    output cic_mode_type charger_mode_select_o,
    output logic [12:0] minimum_system_voltage_mv_o,
    output logic boost_limit_high_o,
    output logic [12:0] fast_charge_current_ma_o,
    output logic reduced_charge_select_o,
    output logic watchdog_reset_o
);
    // ==========================================================
    // helpers
    function automatic logic [12:0] external_current_limit_pin_ma(input logic [2:0] code);
        logic [12:0] ma;
        ma = 13'h064;
        unique case (code)
            3'h0: ma = 13'h064;
            3'h1: ma = 13'h096;
            3'h2: ma = 13'h1F4;
            3'h3: ma = 13'h384;
            3'h4: ma = 13'h4B0;
            3'h5: ma = 13'h5DC;
            3'h6: ma = 13'h7D0;
            3'h7: ma = 13'hBB8;
        endcase
        return ma;
    endfunction
    function automatic logic [12:0] scale(input logic [12:0] ofs, input logic [12:0] step,
                                          input logic [5:0] code);
        logic [18:0] p;
        p = 19'(step) * 19'(code);
        return 13'(p) + ofs;
    endfunction
    // ==========================================================
    // bus state
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_WDATA, ST_WACK, ST_RDATA, ST_RACK
    } cic_state_type;

    cic_state_type state_reg, state_next;
    logic [7:0] shift_reg, shift_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [7:0] ptr_reg, ptr_next;
    logic oe_reg, oe_next, rw_reg, rw_next;
    logic scl_prev_reg, sda_prev_reg, wr_en;
    logic [7:0] rd_data;
    logic [7:0] src_reg, src_next;
    logic [5:0] pwr_reg, pwr_next;
    logic [7:0] chg_reg, chg_next;
    logic init_pending_reg, init_pending_next, wdog_reg, wdog_next;
    logic [2:0] external_current_limit_pin_default;
    // line edges and bus conditions against the previous sample
    wire scl_rise = scl_i & ~scl_prev_reg;
    wire scl_fall = ~scl_i & scl_prev_reg;
    wire start_cond = scl_i & scl_prev_reg & sda_prev_reg & ~sda_i;
    wire stop_cond = scl_i & scl_prev_reg & ~sda_prev_reg & sda_i;
    // read view; unheld offsets read zero, control strobes read back 0
    always_comb begin
        unique case (ptr_reg)
            CIC_OFS_INPUT_SOURCE: rd_data = src_reg;
            CIC_OFS_POWER_ON: rd_data = {2'h0, pwr_reg};
            CIC_OFS_CHARGE_CURRENT: rd_data = chg_reg;
            default: rd_data = 8'h00;
        endcase
    end

    // ==========================================================
    // i2c slave sequencing; sda changes only while scl is low
    always_comb begin
        state_next = state_reg;
        shift_next = shift_reg;
        cnt_next = cnt_reg;
        ptr_next = ptr_reg;
        oe_next = oe_reg;
        rw_next = rw_reg;
        wr_en = 1'b0;
        if (start_cond) begin
            state_next = ST_ADDR;
            cnt_next = 4'h0;
            oe_next = 1'b0;
        end else if (stop_cond) begin
            state_next = ST_IDLE;
            oe_next = 1'b0;
        end else begin
            unique case (state_reg)
                ST_IDLE: oe_next = 1'b0;
                ST_ADDR, ST_PTR, ST_WDATA: begin
                    if (scl_rise) begin
                        shift_next = {shift_reg[6:0], sda_i};
                        cnt_next = cnt_reg + 4'h1;
                    end else if (scl_fall && cnt_reg == CIC_BITS_PER_BYTE) begin
                        cnt_next = 4'h0;
                        oe_next = 1'b1;
                        if (state_reg == ST_ADDR) begin
                            rw_next = shift_reg[0];
                            if (shift_reg[7:1] == CIC_SLAVE_ADDR) begin
                                state_next = ST_ADDR_ACK;
                            end else begin
                                state_next = ST_IDLE;
                                oe_next = 1'b0;
                            end
                        end else if (state_reg == ST_PTR) begin
                            ptr_next = shift_reg;
                            state_next = ST_WACK;
                        end else begin
                            wr_en = 1'b1;
                            ptr_next = ptr_reg + 8'h01;
                            state_next = ST_WACK;
                        end
                    end
                end
                ST_ADDR_ACK, ST_WACK: begin
                    if (scl_fall) begin
                        oe_next = 1'b0;
                        if (state_reg == ST_ADDR_ACK && rw_reg) begin
                            state_next = ST_RDATA;
                            shift_next = rd_data;
                            oe_next = ~rd_data[7];
                        end else begin
                            state_next = (state_reg == ST_ADDR_ACK) ? ST_PTR : ST_WDATA;
                        end
                    end
                end
                ST_RDATA: begin
                    if (scl_rise) begin
                        cnt_next = cnt_reg + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt_reg == CIC_BITS_PER_BYTE) begin
                            oe_next = 1'b0;
                            cnt_next = 4'h0;
                            ptr_next = ptr_reg + 8'h01;
                            state_next = ST_RACK;
                        end else begin
                            shift_next = {shift_reg[6:0], 1'b0};
                            oe_next = ~shift_reg[6];
                        end
                    end
                end
                ST_RACK: begin
                    // a master nack ends the read burst
                    if (scl_rise && sda_i) begin
                        state_next = ST_IDLE;
                    end else if (scl_fall) begin
                        state_next = ST_RDATA;
                        shift_next = rd_data;
                        oe_next = ~rd_data[7];
                    end
                end
            endcase
        end
    end
    // bus registers; line history resets to the idle high level
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_reg <= ST_IDLE;
            shift_reg <= 8'h00;
            cnt_reg <= 4'h0;
            ptr_reg <= 8'h00;
            oe_reg <= 1'b0;
            rw_reg <= 1'b0;
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            shift_reg <= shift_next;
            cnt_reg <= cnt_next;
            ptr_reg <= ptr_next;
            oe_reg <= oe_next;
            rw_reg <= rw_next;
            scl_prev_reg <= scl_i;
            sda_prev_reg <= sda_i;
        end
    end
    // ==========================================================
    // register bank
    // the current default follows the straps, so it is taken one clock after
    // reset release rather than under the asynchronous reset
    always_comb begin
        if (source_is_dcp_i) begin
            external_current_limit_pin_default = CIC_EXTERNAL_CURRENT_LIMIT_PIN_DEF_DCP;
        end else begin
            external_current_limit_pin_default = otg_pin_i ? CIC_EXTERNAL_CURRENT_LIMIT_PIN_DEF_SDP_OTG_HIGH : CIC_EXTERNAL_CURRENT_LIMIT_PIN_DEF_SDP_OTG_LOW;
        end
    end
    // writes, register reset and the strap default load
    always_comb begin
        src_next = src_reg;
        pwr_next = pwr_reg;
        chg_next = chg_reg;
        init_pending_next = 1'b0;
        wdog_next = 1'b0;
        if (init_pending_reg) begin
            src_next[CIC_EXTERNAL_CURRENT_LIMIT_PIN_LSB +: 3] = external_current_limit_pin_default;
        end
        if (wr_en) begin
            unique case (ptr_reg)
                CIC_OFS_INPUT_SOURCE: src_next = shift_reg;
                CIC_OFS_POWER_ON: begin
                    pwr_next = shift_reg[5:0];
                    wdog_next = shift_reg[CIC_WDOG_RESET_BIT];
                    if (shift_reg[CIC_REG_RESET_BIT]) begin
                        // full restore, straps re-sampled on the following clock
                        src_next = CIC_RST_INPUT_SOURCE;
                        pwr_next = CIC_RST_POWER_ON[5:0];
                        chg_next = CIC_RST_CHARGE_CURRENT;
                        init_pending_next = 1'b1;
                    end
                end
                CIC_OFS_CHARGE_CURRENT: begin
                    chg_next = shift_reg;
                    chg_next[CIC_RESERVED_BIT] = 1'b0;
                end
                default: ;
            endcase
        end
    end
    // bank registers; reset loads the fixed defaults
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            src_reg <= CIC_RST_INPUT_SOURCE;
            pwr_reg <= CIC_RST_POWER_ON[5:0];
            chg_reg <= CIC_RST_CHARGE_CURRENT;
            init_pending_reg <= 1'b1;
            wdog_reg <= 1'b0;
        end else begin
            src_reg <= src_next;
            pwr_reg <= pwr_next;
            chg_reg <= chg_next;
            init_pending_reg <= init_pending_next;
            wdog_reg <= wdog_next;
        end
    end
    // ==========================================================
    // decoded settings
    logic [12:0] external_current_limit_pin_reg_ma;
    logic [12:0] fast_charge_current_prog_ma;
    logic [16:0] fast_charge_current_scaled;
    always_comb begin
        external_current_limit_pin_reg_ma = external_current_limit_pin_ma(src_reg[CIC_EXTERNAL_CURRENT_LIMIT_PIN_LSB +: 3]);
        fast_charge_current_prog_ma = scale(CIC_FAST_CHARGE_CURRENT_OFFSET_MA, CIC_FAST_CHARGE_CURRENT_STEP_MA, chg_reg[CIC_FAST_CHARGE_CURRENT_LSB +: 6]);
        // integer percent; rounding toward zero is below the loop accuracy
        fast_charge_current_scaled = chg_reg[CIC_REDUCED_BIT] ?
            (17'(fast_charge_current_prog_ma) * CIC_REDUCED_PCT) / CIC_FULL_PCT : 17'(fast_charge_current_prog_ma);
    end
    // open drain data and the decoded settings
    assign sda_o = 1'b0;
    assign sda_oe_o = oe_reg;
    assign watchdog_reset_o = wdog_reg;
    assign input_high_z_enable_o = src_reg[CIC_HIZ_BIT];
    assign input_voltage_limit_mv_o = scale(CIC_VLIM_OFFSET_MV, CIC_VLIM_STEP_MV,
                                            {2'h0, src_reg[CIC_VLIM_LSB +: 4]});
    assign input_current_limit_ma_o = (external_current_limit_pin_reg_ma < external_current_limit_pin_ma_i) ?
                                      external_current_limit_pin_reg_ma : external_current_limit_pin_ma_i;
    assign charger_mode_select_o = cic_mode_type'(pwr_reg[CIC_MODE_LSB +: 2]);
    assign minimum_system_voltage_mv_o = scale(CIC_SYSMIN_OFFSET_MV, CIC_SYSMIN_STEP_MV,
                                               {3'h0, pwr_reg[CIC_SYSMIN_LSB +: 3]});
    assign boost_limit_high_o = pwr_reg[CIC_BOOST_BIT];
    assign fast_charge_current_ma_o = fast_charge_current_scaled[12:0];
    assign reduced_charge_select_o = chg_reg[CIC_REDUCED_BIT];
endmodule

// ### common/cic_pkg.sv
// constants for the charger input configuration register bank
package cic_pkg;
    // ==========================================================
    // serial bus
    localparam logic [6:0] CIC_SLAVE_ADDR = 7'h6B;
    localparam logic [3:0] CIC_BITS_PER_BYTE = 4'h8;

    // ==========================================================
    // register offsets
    localparam logic [7:0] CIC_OFS_INPUT_SOURCE = 8'h00;
    localparam logic [7:0] CIC_OFS_POWER_ON = 8'h01;
    localparam logic [7:0] CIC_OFS_CHARGE_CURRENT = 8'h02;

    // ==========================================================
    // reset values
    localparam logic [7:0] CIC_RST_INPUT_SOURCE = 8'h38;
    localparam logic [7:0] CIC_RST_POWER_ON = 8'h1B;
    localparam logic [7:0] CIC_RST_CHARGE_CURRENT = 8'h20;
    localparam logic [2:0] CIC_EXTERNAL_CURRENT_LIMIT_PIN_DEF_SDP_OTG_LOW = 3'h0;
    localparam logic [2:0] CIC_EXTERNAL_CURRENT_LIMIT_PIN_DEF_SDP_OTG_HIGH = 3'h2;
    localparam logic [2:0] CIC_EXTERNAL_CURRENT_LIMIT_PIN_DEF_DCP = 3'h5;

    // ==========================================================
    // field positions
    localparam int CIC_HIZ_BIT = 7;
    localparam int CIC_VLIM_LSB = 3;
    localparam int CIC_EXTERNAL_CURRENT_LIMIT_PIN_LSB = 0;
    localparam int CIC_REG_RESET_BIT = 7;
    localparam int CIC_WDOG_RESET_BIT = 6;
    localparam int CIC_MODE_LSB = 4;
    localparam int CIC_SYSMIN_LSB = 1;
    localparam int CIC_BOOST_BIT = 0;
    localparam int CIC_FAST_CHARGE_CURRENT_LSB = 2;
    localparam int CIC_RESERVED_BIT = 1;
    localparam int CIC_REDUCED_BIT = 0;

    // ==========================================================
    // scaling of the decoded fields
    localparam logic [12:0] CIC_VLIM_OFFSET_MV = 13'hF28;
    localparam logic [12:0] CIC_VLIM_STEP_MV = 13'h050;
    localparam logic [12:0] CIC_SYSMIN_OFFSET_MV = 13'hBB8;
    localparam logic [12:0] CIC_SYSMIN_STEP_MV = 13'h064;
    localparam logic [12:0] CIC_FAST_CHARGE_CURRENT_OFFSET_MA = 13'h200;
    localparam logic [12:0] CIC_FAST_CHARGE_CURRENT_STEP_MA = 13'h040;
    localparam logic [16:0] CIC_REDUCED_PCT = 17'h00014;
    localparam logic [16:0] CIC_FULL_PCT = 17'h00064;

    // ==========================================================
    // charger modes
    typedef enum logic [1:0] {
        CIC_MODE_DISABLE,
        CIC_MODE_CHARGE,
        CIC_MODE_OTG_A,
        CIC_MODE_OTG_B
    } cic_mode_type;
endpackage

// ### sim/cic_host_model.sv
// i2c master model standing in for the host processor
`timescale 1ns/1ps
module cic_host_model
    import cic_pkg::*;
(
    // clock
    input wire logic sys_clk_i,
    // i2c wire, pulled up when nobody pulls
    input wire logic sda_line_i,
    output logic scl_o,
    output logic sda_pull_o
);
    // bus released at time zero
    initial begin
        scl_o = 1'b1;
        sda_pull_o = 1'b0;
    end
    // set both lines after an edge and hold them n clocks
    task automatic drive(input logic c, input logic p, input int n);
        scl_o <= c;
        sda_pull_o <= p;
        repeat (n) @(posedge sys_clk_i);
    endtask
    // start or repeated start: sda falls while scl is high
    task automatic start();
        drive(scl_o, 1'b0, 2);
        drive(1'b1, 1'b0, 4);
        drive(1'b1, 1'b1, 4);
        drive(1'b0, 1'b1, 1);
    endtask
    task automatic stop();
        drive(1'b0, 1'b1, 2);
        drive(1'b1, 1'b1, 4);
        drive(1'b1, 1'b0, 4);
    endtask
    // sda only moves while scl is low; sampled mid high phase
    task automatic bit_io(input logic b, output logic r);
        drive(1'b0, !b, 4);
        drive(1'b1, !b, 2);
        r = sda_line_i;
        drive(1'b1, !b, 2);
        drive(1'b0, !b, 1);
    endtask
    // eight bits msb first, then the acknowledge bit
    task automatic xfer(input logic [7:0] tx, input logic ack, output logic [7:0] rx,
                        output logic got);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], r);
            rx[i] = r;
        end
        bit_io(!ack, r);
        got = !r;
    endtask
    task automatic wr(input logic [6:0] dev, input logic [7:0] p, input logic [7:0] d,
                      output logic ok);
        logic [7:0] rx;
        logic a;
        logic b;
        logic c;
        start();
        xfer({dev, 1'b0}, 1'b0, rx, a);
        xfer(p, 1'b0, rx, b);
        xfer(d, 1'b0, rx, c);
        stop();
        ok = a & b & c;
    endtask
    // pointer write, repeated start, one byte ended by a nack
    task automatic rd(input logic [7:0] p, output logic [7:0] d);
        logic [7:0] rx;
        logic a;
        start();
        xfer({CIC_SLAVE_ADDR, 1'b0}, 1'b0, rx, a);
        xfer(p, 1'b0, rx, a);
        start();
        xfer({CIC_SLAVE_ADDR, 1'b1}, 1'b0, rx, a);
        xfer(8'hFF, 1'b0, d, a);
        stop();
    endtask
    // pointer write, repeated start, two bytes: the first acked, the last nacked
    task automatic rd2(input logic [7:0] p, output logic [7:0] d0, output logic [7:0] d1);
        logic [7:0] rx;
        logic a;
        start();
        xfer({CIC_SLAVE_ADDR, 1'b0}, 1'b0, rx, a);
        xfer(p, 1'b0, rx, a);
        start();
        xfer({CIC_SLAVE_ADDR, 1'b1}, 1'b0, rx, a);
        xfer(8'hFF, 1'b1, d0, a);
        xfer(8'hFF, 1'b0, d1, a);
        stop();
    endtask
endmodule

// ### sim/cic_regs_chk.sv
// port assertions for the charger input configuration registers
`timescale 1ns/1ps
module cic_regs_chk
    import cic_pkg::*;
(
    // clock, reset, bus and straps
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic otg_pin_i,
    input wire logic source_is_dcp_i,
    input wire logic [12:0] external_current_limit_pin_ma_i,
    // decoded settings
    input wire logic input_high_z_enable_o,
    input wire logic [12:0] input_voltage_limit_mv_o,
    input wire logic [12:0] input_current_limit_ma_o,
    input wire cic_mode_type charger_mode_select_o,
    input wire logic [12:0] minimum_system_voltage_mv_o,
    input wire logic boost_limit_high_o,
    input wire logic [12:0] fast_charge_current_ma_o,
    input wire logic reduced_charge_select_o,
    input wire logic watchdog_reset_o
);
    // strap default, capped by the pin, expected after reset release
    logic [12:0] def_ma;
    logic [12:0] cap_ma;
    assign def_ma = source_is_dcp_i ? 13'h5DC : (otg_pin_i ? 13'h1F4 : 13'h064);
    assign cap_ma = (def_ma < external_current_limit_pin_ma_i) ? def_ma
                    : external_current_limit_pin_ma_i;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    AST_VLIM: assert property (
        input_voltage_limit_mv_o inside {[13'hF28:13'h13D8]}
        && (input_voltage_limit_mv_o - 13'hF28) % 13'h50 == 13'h0) else $error("vlim off grid");
    AST_SYSMIN: assert property (
        minimum_system_voltage_mv_o inside {[13'hBB8:13'hE74]}
        && (minimum_system_voltage_mv_o - 13'hBB8) % 13'h64 == 13'h0) else $error("sysmin bad");
    AST_FAST_CHARGE_CURRENT: assert property (!reduced_charge_select_o |->
        fast_charge_current_ma_o inside {[13'h200:13'h11C0]}
        && (fast_charge_current_ma_o - 13'h200) % 13'h40 == 13'h0) else $error("fast_charge_current bad");
    AST_REDUCED: assert property (
        reduced_charge_select_o |-> fast_charge_current_ma_o <= 13'h38C
        && fast_charge_current_ma_o >= 13'h066) else $error("20pct bad");
    AST_EXTERNAL_CURRENT_LIMIT_PIN_MIN: assert property (
        input_current_limit_ma_o <= external_current_limit_pin_ma_i
        && (input_current_limit_ma_o == external_current_limit_pin_ma_i
        || input_current_limit_ma_o inside {13'h064, 13'h096, 13'h1F4, 13'h384, 13'h4B0,
        13'h5DC, 13'h7D0, 13'hBB8})) else $error("external_current_limit_pin over pin");
    AST_WDOG: assert property (
        watchdog_reset_o |=> !watchdog_reset_o [*2]) else $error("wdog pulse long");
    AST_RESET_DEF: assert property ($fell(reset_i) |->
        input_voltage_limit_mv_o == 13'h1158 && minimum_system_voltage_mv_o == 13'hDAC
        && charger_mode_select_o == CIC_MODE_CHARGE && boost_limit_high_o && !input_high_z_enable_o
        && fast_charge_current_ma_o == 13'h400 && !reduced_charge_select_o) else $error("reset bad");
    AST_EXTERNAL_CURRENT_LIMIT_PIN_DEF: assert property (
        $fell(reset_i) |=> input_current_limit_ma_o == cap_ma) else $error("strap default bad");
endmodule
bind cic_regs cic_regs_chk chk (.*);

// ### sim/tb_cic_regs.sv
// self-checking bench for the charger input configuration registers
`timescale 1ns/1ps
module tb_cic_regs
    import cic_pkg::*;
;
    logic sys_clk_i, reset_i, otg_pin, dcp, scl, sda_pull, sda_oe, sda_line, wdog, hiz, boost;
    logic reduced;
    logic [12:0] pin_ma, vlim, external_current_limit_pin, sysmin, fast_charge_current;
    cic_mode_type mode;
    int n_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    int wd_cnt = 0;
    // open-drain wire with pull-up
    assign sda_line = !(sda_oe | sda_pull);
    cic_regs uut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .scl_i(scl), .sda_i(sda_line),
        .sda_o(), .sda_oe_o(sda_oe), .otg_pin_i(otg_pin), .source_is_dcp_i(dcp),
        .external_current_limit_pin_ma_i(pin_ma), .input_high_z_enable_o(hiz),
        .input_voltage_limit_mv_o(vlim), .input_current_limit_ma_o(external_current_limit_pin),
        .charger_mode_select_o(mode), .minimum_system_voltage_mv_o(sysmin),
        .boost_limit_high_o(boost), .fast_charge_current_ma_o(fast_charge_current),
        .reduced_charge_select_o(reduced), .watchdog_reset_o(wdog));
    cic_host_model host (.sys_clk_i(sys_clk_i), .sda_line_i(sda_line), .scl_o(scl),
        .sda_pull_o(sda_pull));
    task automatic wrap_up();
        if (n_errors == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [12:0] got, input logic [12:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %0h want %0h", $time, got, exp);
        end
    endtask
    // write expecting every byte acknowledged
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        logic ok;
        host.wr(CIC_SLAVE_ADDR, p, d, ok);
        chk({12'h000, ok}, 13'h0001);
    endtask
    task automatic rd(input logic [7:0] p, input logic [7:0] e);
        logic [7:0] d;
        host.rd(p, d);
        chk({5'h00, d}, {5'h00, e});
    endtask
    // defaults with a standard port and the otg strap high
    task automatic t_defaults();
        rd(CIC_OFS_INPUT_SOURCE, 8'h3A);
        rd(CIC_OFS_POWER_ON, 8'h1B);
        rd(CIC_OFS_CHARGE_CURRENT, 8'h20);
        chk(external_current_limit_pin, 13'h1F4);
    endtask
    // every current code, then the pin caps the limit
    task automatic t_external_current_limit_pin();
        logic [12:0] tbl [8] = '{13'h064, 13'h096, 13'h1F4, 13'h384, 13'h4B0, 13'h5DC,
                                  13'h7D0, 13'hBB8};
        for (int c = 0; c < 8; c++) begin
            wr(CIC_OFS_INPUT_SOURCE, 8'hF8 | 8'(c));
            chk(external_current_limit_pin, tbl[c]);
            chk(vlim, 13'h13D8);
            chk({12'h000, hiz}, 13'h0001);
        end
        pin_ma <= 13'h2BC;
        repeat (2) @(posedge sys_clk_i);
        chk(external_current_limit_pin, 13'h2BC);
        pin_ma <= 13'hBB8;
        wr(CIC_OFS_INPUT_SOURCE, 8'h00);
        chk(vlim, 13'hF28);
        chk({12'h000, hiz}, 13'h0000);
    endtask
    // all modes, lowest system voltage, low boost limit, watchdog strobe
    task automatic t_mode();
        for (int m = 0; m < 4; m++) begin
            wr(CIC_OFS_POWER_ON, 8'(m << 4));
            chk({11'h000, mode}, 13'(m));
            chk(sysmin, 13'hBB8);
            chk({12'h000, boost}, 13'h0000);
        end
        wr(CIC_OFS_POWER_ON, 8'h5F);
        rd(CIC_OFS_POWER_ON, 8'h1F);
        chk(sysmin, 13'hE74);
        chk({12'h000, boost}, 13'h0001);
        chk(13'(wd_cnt), 13'h0001);
    endtask
    // reduced current, reserved bit, then full scale
    task automatic t_charge();
        wr(CIC_OFS_CHARGE_CURRENT, 8'hFF);
        rd(CIC_OFS_CHARGE_CURRENT, 8'hFD);
        chk(fast_charge_current, 13'h38C);
        chk({12'h000, reduced}, 13'h0001);
        wr(CIC_OFS_CHARGE_CURRENT, 8'hFE);
        chk(fast_charge_current, 13'h11C0);
        chk({12'h000, reduced}, 13'h0000);
        wr(CIC_OFS_CHARGE_CURRENT, 8'h41);
        chk(fast_charge_current, 13'h133);
        chk({12'h000, reduced}, 13'h0001);
    endtask
    // register reset reloads defaults with the new strap
    task automatic t_reset();
        dcp <= 1'b1;
        wr(CIC_OFS_POWER_ON, 8'h80);
        rd(CIC_OFS_INPUT_SOURCE, 8'h3D);
        rd(CIC_OFS_POWER_ON, 8'h1B);
        rd(CIC_OFS_CHARGE_CURRENT, 8'h20);
    endtask
    // two-byte read burst walks the pointer from one register to the next
    task automatic t_burst();
        logic [7:0] d0;
        logic [7:0] d1;
        host.rd2(CIC_OFS_POWER_ON, d0, d1);
        chk({5'h00, d0}, 13'h001B);
        chk({5'h00, d1}, 13'h0020);
    endtask
    // foreign address is ignored, unbuilt offset reads zero
    task automatic t_addr();
        logic ok;
        host.wr(7'h6A, CIC_OFS_INPUT_SOURCE, 8'hFF, ok);
        chk({12'h000, ok}, 13'h0000);
        rd(CIC_OFS_INPUT_SOURCE, 8'h3D);
        wr(8'h05, 8'hAA);
        rd(8'h05, 8'h00);
    endtask
    initial begin
        sys_clk_i = 1'b0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end
    // cycle ceiling well above the roughly 10k cycles of traffic
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (wdog === 1'b1)
            wd_cnt <= wd_cnt + 1;
        if (cyc == 60000) begin
            n_errors++;
            wrap_up();
        end
    end
    initial begin
        reset_i = 1'b1;
        otg_pin = 1'b1;
        dcp = 1'b0;
        pin_ma = 13'hBB8;
        repeat (4) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        t_defaults();
        t_external_current_limit_pin();
        t_mode();
        t_charge();
        t_reset();
        t_burst();
        t_addr();
        wrap_up();
    end
endmodule
